// File: fault_response_pkg.sv
// Constants, encodings and decode helpers for the motor fault response block
package fault_response_pkg;
	// ==========================================================
	// Timing
	localparam int CLK_MHZ = 40;
	localparam int GENERAL_RETRY_US = 1000;
	localparam int STALL_RETRY_US = 5000;
	localparam int GENERAL_RETRY_CYC = GENERAL_RETRY_US * CLK_MHZ;
	localparam int STALL_RETRY_CYC = STALL_RETRY_US * CLK_MHZ;
	localparam int CNT_W = 24;
	// ==========================================================
	// Register map
	localparam logic [7:0] CONFIG_OFFSET = 8'h00;
	localparam logic [7:0] CLEAR_OFFSET = 8'h04;
	localparam logic [7:0] STATUS_OFFSET = 8'h08;
	localparam logic [31:0] CONFIG_RESET = 32'h00000000;
	localparam int CFG_OCP_LSB = 0;
	localparam int CFG_STALL_LSB = 4;
	localparam int CFG_HARD_LSB = 8;
	localparam int CLR_BIT = 0;
	localparam int STS_OCP_BIT = 0;
	localparam int STS_STALL_BIT = 8;
	localparam int STS_HARD_BIT = 9;
	localparam int STS_ACT_LSB = 12;
	localparam int STS_PIN_BIT = 16;
	localparam logic [2:0] SIZE_WORD = 3'h2;
	// ==========================================================
	// Sense inputs
	localparam int NUM_PINS = 6;
	localparam int PIN_OCP = 0;
	localparam int PIN_REG = 1;
	localparam int PIN_SPEED = 2;
	localparam int PIN_NOLOCK = 3;
	localparam int PIN_BEMF = 4;
	localparam int PIN_HARD = 5;
	// ==========================================================
	// Output actions and recovery kinds
	localparam logic [1:0] ACT_NORMAL = 2'h0;
	localparam logic [1:0] ACT_HIZ = 2'h1;
	localparam logic [1:0] ACT_LOW = 2'h2;
	localparam logic [1:0] ACT_HIGH = 2'h3;
	localparam logic [1:0] KIND_LATCH = 2'h0;
	localparam logic [1:0] KIND_RETRY = 2'h1;
	localparam logic [1:0] KIND_REPORT = 2'h2;
	localparam logic [1:0] KIND_IGNORE = 2'h3;
	localparam logic [1:0] OCP_LATCH = 2'h0;
	localparam logic [1:0] OCP_RETRY = 2'h1;
	localparam logic [2:0] LOCK_REPORT = 3'h6;
	localparam logic [2:0] LOCK_IGNORE = 3'h7;

	function automatic logic [1:0] lock_action(input logic [2:0] m);
		case (m)
			3'h0, 3'h3: lock_action = ACT_HIZ;
			3'h1, 3'h4: lock_action = ACT_LOW;
			3'h2, 3'h5: lock_action = ACT_HIGH;
			default: lock_action = ACT_NORMAL;
		endcase
	endfunction

	function automatic logic [1:0] lock_kind(input logic [2:0] m);
		case (m)
			3'h0, 3'h1, 3'h2: lock_kind = KIND_LATCH;
			3'h3, 3'h4, 3'h5: lock_kind = KIND_RETRY;
			3'h6: lock_kind = KIND_REPORT;
			default: lock_kind = KIND_IGNORE;
		endcase
	endfunction
endpackage

// File: host_fault_monitor.sv
// Host side model that counts assertions of the fault pin
`timescale 1ns/1ps
module host_fault_monitor (
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// Fault pin
	input wire logic fault_indicator_n,
	// Observations
	output logic [7:0] assert_count
);
	logic pin_q;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pin_q <= 1'b1;
			assert_count <= 8'h00;
		end else begin
			pin_q <= fault_indicator_n;
			// Host notices each new falling edge of the pin
			if (pin_q && !fault_indicator_n) begin
				assert_count <= assert_count + 8'h01;
			end
		end
	end
endmodule

// File: motor_fault_response_control.sv
// Fault channels and AHB-Lite controlled fault response top
//
// Local design decisions: the placing of the registers and the AHB-Lite register port.
`timescale 1ns/1ps

module fault_channel #(
	parameter int RETRY_CYCLES = 1
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	// Condition and configuration
	input wire logic cond,
	input wire logic [1:0] act_sel,
	input wire logic [1:0] kind_sel,
	input wire logic clear,
	// State
	output logic flag,
	output logic [1:0] act,
	output logic latched,
	output logic retrying,
	output logic cnt_zero
);
	import fault_response_pkg::*;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_LATCH = 3'b010,
		ST_RETRY = 3'b100
	} chan_state_type;

	chan_state_type state;
	chan_state_type next_state;
	logic [CNT_W-1:0] cnt;
	logic next_flag;
	logic entering;

	always_comb begin
		next_state = state;
		case (state)
			ST_IDLE: begin
				if (cond && kind_sel == KIND_LATCH) begin
					next_state = ST_LATCH;
				end else if (cond && kind_sel == KIND_RETRY) begin
					next_state = ST_RETRY;
				end
			end
			ST_LATCH: begin
				// Clear loses against a condition still present
				if (clear && !cond) begin
					next_state = ST_IDLE;
				end
			end
			ST_RETRY: begin
				if (cnt_zero) begin
					next_state = ST_IDLE;
				end
			end
			default: next_state = ST_IDLE;
		endcase
	end

	assign entering = (state == ST_IDLE) && (next_state != ST_IDLE);
	assign next_flag = (next_state != ST_IDLE) ||
		(state == ST_IDLE && cond && kind_sel == KIND_REPORT);
	assign cnt_zero = (cnt == '0);
	assign latched = (state == ST_LATCH);
	assign retrying = (state == ST_RETRY);

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			state <= ST_IDLE;
			flag <= 1'b0;
			act <= ACT_NORMAL;
			cnt <= '0;
		end else begin
			state <= next_state;
			flag <= next_flag;
			if (entering) begin
				act <= act_sel;
			end else if (next_state == ST_IDLE) begin
				act <= ACT_NORMAL;
			end
			if (entering) begin
				cnt <= CNT_W'(RETRY_CYCLES - 1);
			end else if (state == ST_RETRY && !cnt_zero) begin
				cnt <= cnt - 1'b1;
			end
		end
	end
endmodule

// Function
// - Phase overcurrent with response 00b forces high impedance, reports, and latches until clear.
// - Phase overcurrent with response 01b forces high impedance, reports, and retries after the general interval.
// - Regulator overcurrent forces high impedance, disables the core, reports nothing, recovers by itself.
// - A rotor stall is flagged on abnormal speed, no-lock, or abnormal back-EMF.
// - Stall responses 000b to 010b give high impedance, low brake, high brake, report, and latch.
// - Stall responses 011b to 101b give the same three actions, report, and retry after the stall interval.
// - Stall response 110b only reports and leaves the outputs running.
// - Stall response 111b ignores the stall completely.
// - The hard stall current fault fires when the sense amplifier exceeds its threshold.
// - Hard stall responses 000b to 010b give the three actions, report, and latch until clear.
// - Hard stall responses 011b to 101b give the three actions, report, and retry after the stall interval.
// - Hard stall response 110b only reports and leaves the outputs switching.
// - Hard stall response 111b neither reports nor acts.
module motor_fault_response_control #(
	parameter int GENERAL_RETRY_CYCLES = fault_response_pkg::GENERAL_RETRY_CYC,
	parameter int STALL_RETRY_CYCLES = fault_response_pkg::STALL_RETRY_CYC
) (
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// Fault sense inputs
	input wire logic phase_overcurrent,
	input wire logic regulator_overcurrent,
	input wire logic abnormal_speed,
	input wire logic no_motor_lock,
	input wire logic abnormal_bemf,
	input wire logic hard_stall_current_fault,
	// Responses
	output logic fault_indicator_n,
	output logic [1:0] output_action,
	output logic core_disable
);
	import fault_response_pkg::*;

	// ==========================================================
	// Input synchronisers
	logic [NUM_PINS-1:0] pin_meta;
	logic [NUM_PINS-1:0] pin_sync;
	logic [NUM_PINS-1:0] pin_raw;

	assign pin_raw = {hard_stall_current_fault, abnormal_bemf, no_motor_lock,
		abnormal_speed, regulator_overcurrent, phase_overcurrent};

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pin_meta <= '0;
			pin_sync <= '0;
		end else begin
			pin_meta <= pin_raw;
			pin_sync <= pin_meta;
		end
	end

	// ==========================================================
	// Bus slave
	logic [31:0] config_reg;
	logic [7:0] addr_q;
	logic wr_pend;
	logic rd_pend;
	logic clear_cmd;
	logic [31:0] status_word;
	logic [31:0] read_mux;
	logic take;
	logic ocp_flag, stall_flag, hard_flag;

	assign take = hsel && hready && htrans[1];
	assign status_word = (32'(ocp_flag) << STS_OCP_BIT) | (32'(stall_flag) << STS_STALL_BIT) |
		(32'(hard_flag) << STS_HARD_BIT) | (32'(output_action) << STS_ACT_LSB) |
		(32'(!fault_indicator_n) << STS_PIN_BIT);
	assign read_mux = (addr_q == CONFIG_OFFSET) ? config_reg :
		(addr_q == STATUS_OFFSET) ? status_word : 32'h00000000;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			config_reg <= CONFIG_RESET;
			addr_q <= 8'h00;
			wr_pend <= 1'b0;
			rd_pend <= 1'b0;
			clear_cmd <= 1'b0;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			hrdata <= 32'h00000000;
		end else begin
			wr_pend <= take && hwrite && hsize == SIZE_WORD;
			rd_pend <= take && !hwrite;
			if (take) begin
				addr_q <= haddr[7:0];
			end
			// One wait state on reads so a preceding write is seen
			if (take && !hwrite) begin
				hreadyout <= 1'b0;
			end else if (rd_pend) begin
				hreadyout <= 1'b1;
				hrdata <= read_mux;
			end
			if (wr_pend && addr_q == CONFIG_OFFSET) begin
				config_reg <= hwdata;
			end
			clear_cmd <= wr_pend && addr_q == CLEAR_OFFSET && hwdata[CLR_BIT];
		end
	end

	// ==========================================================
	// Fault channels
	logic [1:0] ocp_resp;
	logic [2:0] stall_resp;
	logic [2:0] hard_resp;
	logic ocp_cond;
	logic stall_cond;
	logic hard_cond;
	logic [1:0] ocp_kind;
	logic [1:0] ocp_act, stall_act, hard_act;
	logic ocp_latched, stall_latched, hard_latched;
	logic ocp_retrying, stall_retrying, hard_retrying;
	logic ocp_zero, stall_zero, hard_zero;

	assign ocp_resp = config_reg[CFG_OCP_LSB +: 2];
	assign stall_resp = config_reg[CFG_STALL_LSB +: 3];
	assign hard_resp = config_reg[CFG_HARD_LSB +: 3];
	assign ocp_cond = pin_sync[PIN_OCP];
	assign ocp_kind = (ocp_resp == OCP_RETRY) ? KIND_RETRY : KIND_LATCH;
	assign stall_cond = pin_sync[PIN_SPEED] || pin_sync[PIN_NOLOCK] ||
		pin_sync[PIN_BEMF];
	assign hard_cond = pin_sync[PIN_HARD];

	fault_channel #(.RETRY_CYCLES(GENERAL_RETRY_CYCLES)) ocp_chan (
		.clk(hclk), .rstn(hresetn), .cond(ocp_cond), .act_sel(ACT_HIZ),
		.kind_sel(ocp_kind), .clear(clear_cmd), .flag(ocp_flag), .act(ocp_act),
		.latched(ocp_latched), .retrying(ocp_retrying), .cnt_zero(ocp_zero)
	);

	// Lock style responses decoded per mode
	fault_channel #(.RETRY_CYCLES(STALL_RETRY_CYCLES)) stall_chan (
		.clk(hclk), .rstn(hresetn), .cond(stall_cond),
		.act_sel(lock_action(stall_resp)), .kind_sel(lock_kind(stall_resp)),
		.clear(clear_cmd), .flag(stall_flag), .act(stall_act),
		.latched(stall_latched), .retrying(stall_retrying), .cnt_zero(stall_zero)
	);

	// Same decode for the hard stall limit
	fault_channel #(.RETRY_CYCLES(STALL_RETRY_CYCLES)) hard_chan (
		.clk(hclk), .rstn(hresetn), .cond(hard_cond),
		.act_sel(lock_action(hard_resp)), .kind_sel(lock_kind(hard_resp)),
		.clear(clear_cmd), .flag(hard_flag), .act(hard_act),
		.latched(hard_latched), .retrying(hard_retrying), .cnt_zero(hard_zero)
	);

	// ==========================================================
	// Output stage arbitration
	logic any_hiz, any_low, any_high, any_flag;
	logic [1:0] next_action;

	assign any_hiz = pin_sync[PIN_REG] || ocp_act == ACT_HIZ ||
		stall_act == ACT_HIZ || hard_act == ACT_HIZ;
	assign any_low = stall_act == ACT_LOW || hard_act == ACT_LOW;
	assign any_high = stall_act == ACT_HIGH || hard_act == ACT_HIGH;
	assign next_action = any_hiz ? ACT_HIZ : any_low ? ACT_LOW :
		any_high ? ACT_HIGH : ACT_NORMAL;
	assign any_flag = ocp_flag || stall_flag || hard_flag;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			output_action <= ACT_NORMAL;
			core_disable <= 1'b0;
			fault_indicator_n <= 1'b1;
		end else begin
			output_action <= next_action;
			core_disable <= pin_sync[PIN_REG];
			fault_indicator_n <= !any_flag;
		end
	end

	// ==========================================================
	// Assertions
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	logic ocp_idle, stall_idle, hard_idle;
	assign ocp_idle = !ocp_latched && !ocp_retrying;
	assign stall_idle = !stall_latched && !stall_retrying;
	assign hard_idle = !hard_latched && !hard_retrying;

	a_ocp_latch_entry: assert property (ocp_idle && ocp_cond && ocp_resp == OCP_LATCH
		|=> ocp_latched && ocp_flag ##1 output_action == ACT_HIZ)
		else $error("phase overcurrent did not latch high impedance");
	a_ocp_latch_hold: assert property (ocp_latched && !clear_cmd |=> ocp_latched)
		else $error("phase overcurrent latch dropped without clear");
	a_ocp_retry_entry: assert property (ocp_idle && ocp_cond && ocp_resp == OCP_RETRY
		|=> ocp_retrying && ocp_flag && ocp_act == ACT_HIZ)
		else $error("phase overcurrent retry not started");
	a_reg_oc_hiz: assert property (pin_sync[PIN_REG]
		|=> output_action == ACT_HIZ && core_disable)
		else $error("regulator overcurrent not handled");
	a_stall_detect: assert property (stall_idle && stall_cond && stall_resp != LOCK_IGNORE
		|=> stall_flag)
		else $error("stall condition not flagged");
	a_stall_latch: assert property (stall_idle && stall_cond && stall_resp < 3'h3
		|=> stall_latched && stall_act == lock_action($past(stall_resp)))
		else $error("stall latch action wrong");
	a_stall_retry: assert property (stall_idle && stall_cond && stall_resp inside {3'h3, 3'h4, 3'h5}
		|=> stall_retrying && stall_act == lock_action($past(stall_resp)))
		else $error("stall retry action wrong");
	a_stall_report: assert property (stall_idle && stall_cond && stall_resp == LOCK_REPORT
		|=> stall_flag && stall_act == ACT_NORMAL)
		else $error("stall report-only mode acted");
	a_stall_ignore: assert property (stall_idle && stall_resp == LOCK_IGNORE
		|=> !stall_flag && stall_idle)
		else $error("ignored stall was reported");
	a_hard_latch: assert property (hard_idle && hard_cond && hard_resp < 3'h3
		|=> hard_latched && hard_flag && hard_act == lock_action($past(hard_resp)))
		else $error("hard stall latch action wrong");
	a_hard_retry: assert property (hard_idle && hard_cond && hard_resp inside {3'h3, 3'h4, 3'h5}
		|=> hard_retrying && hard_act == lock_action($past(hard_resp)))
		else $error("hard stall retry action wrong");
	a_hard_report: assert property (hard_idle && hard_cond && hard_resp == LOCK_REPORT
		|=> hard_flag && hard_act == ACT_NORMAL)
		else $error("hard stall report-only mode acted");
	a_hard_ignore: assert property (hard_idle && hard_resp == LOCK_IGNORE
		|=> !hard_flag && hard_idle)
		else $error("ignored hard stall was reported");
	a_pin_follows: assert property (1'b1 |=> fault_indicator_n == !$past(any_flag))
		else $error("fault pin does not follow pending faults");
	a_retry_hold: assert property (stall_retrying && !stall_zero
		|=> stall_retrying && stall_act == $past(stall_act))
		else $error("retry ended early");
	a_retry_end: assert property (ocp_retrying && ocp_zero
		|=> !ocp_retrying && ocp_act == ACT_NORMAL)
		else $error("retry did not restore outputs");
	a_hard_retry_end: assert property (hard_retrying && hard_zero |=> !hard_retrying && hard_act == ACT_NORMAL)
		else $error("hard stall retry did not restore outputs");

	c_ocp_latch_clear: cover property (ocp_latched ##1 clear_cmd ##1 ocp_idle);
	c_stall_retry_done: cover property (stall_retrying && stall_zero ##1 stall_idle);
	c_hard_low_brake: cover property (hard_act == ACT_LOW ##1 output_action == ACT_LOW);
	c_reg_oc: cover property (core_disable ##1 !core_disable);
endmodule

// File: motor_fault_response_control_tb_top.sv
// Self-checking bench for the motor fault response block
`timescale 1ns/1ps
module motor_fault_response_control_tb_top;
	import fault_response_pkg::*;
	localparam int GEN_CYC = 8;
	localparam int STALL_CYC = 12;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h00000000;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [2:0] hsize = 3'h0;
	logic [31:0] hwdata = 32'h00000000;
	logic hreadyout;
	logic hresp;
	logic [31:0] hrdata;
	logic [5:0] sense = 6'h00;
	logic fault_indicator_n;
	logic core_disable;
	logic [1:0] output_action;
	logic [7:0] assert_count;
	logic [31:0] rd;
	int err_count = 0;
	int n_tests = 0;
	int cycles = 0;

	always #12.5 hclk = ~hclk;

	motor_fault_response_control #(
		.GENERAL_RETRY_CYCLES(GEN_CYC),
		.STALL_RETRY_CYCLES(STALL_CYC)
	) i_motor_fault_response_control (
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.phase_overcurrent(sense[PIN_OCP]), .regulator_overcurrent(sense[PIN_REG]),
		.abnormal_speed(sense[PIN_SPEED]), .no_motor_lock(sense[PIN_NOLOCK]),
		.abnormal_bemf(sense[PIN_BEMF]), .hard_stall_current_fault(sense[PIN_HARD]),
		.fault_indicator_n(fault_indicator_n), .output_action(output_action),
		.core_disable(core_disable)
	);

	host_fault_monitor i_host_fault_monitor (
		.hclk(hclk), .hresetn(hresetn), .fault_indicator_n(fault_indicator_n),
		.assert_count(assert_count)
	);

	task automatic final_report();
		$display("comparisons %0d mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	// Hang guard
	always @(posedge hclk) begin
		cycles++;
		if (cycles == 3000) begin
			err_count++;
			final_report();
		end
	end

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			err_count++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// Single AHB-Lite transfer, waits on the slave's ready
	task automatic ahb_xfer(input logic wr, input logic [7:0] addr, input logic [2:0] sz,
		input logic [31:0] data, output logic [31:0] rdata);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= {24'h000000, addr};
		htrans <= 2'h2;
		hwrite <= wr;
		hsize <= sz;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hsel <= 1'b0;
		hwdata <= data;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rdata = hrdata;
		check(32'(hresp), 32'h0);
	endtask

	task automatic ahb_write(input logic [7:0] addr, input logic [31:0] data);
		logic [31:0] unused;
		ahb_xfer(1'b1, addr, SIZE_WORD, data, unused);
	endtask

	task automatic ahb_read(input logic [7:0] addr, output logic [31:0] data);
		ahb_xfer(1'b0, addr, SIZE_WORD, 32'h00000000, data);
	endtask

	function automatic logic [1:0] exp_act(input int m);
		if (m > 5) begin
			return ACT_NORMAL;
		end
		return (m % 3 == 0) ? ACT_HIZ : (m % 3 == 1) ? ACT_LOW : ACT_HIGH;
	endfunction

	// One stall or hard stall episode under mode m
	task automatic fault_case(input int f, input int m);
		int pin;
		int flag_bit;
		logic [1:0] act;
		logic rep;
		pin = (f != 0) ? PIN_HARD : PIN_SPEED + m % 3;
		flag_bit = (f != 0) ? STS_HARD_BIT : STS_STALL_BIT;
		act = exp_act(m);
		rep = (m != 7);
		ahb_write(CONFIG_OFFSET, 32'(m) << ((f != 0) ? CFG_HARD_LSB : CFG_STALL_LSB));
		sense <= sense | (6'h01 << pin);
		repeat (6) @(posedge hclk);
		check(32'(output_action), 32'(act));
		check(32'(fault_indicator_n), 32'(!rep));
		ahb_read(STATUS_OFFSET, rd);
		check(rd, (32'(rep) << flag_bit) | (32'(act) << STS_ACT_LSB) | (32'(rep) << STS_PIN_BIT));
		sense <= 6'h00;
		repeat (4) @(posedge hclk);
		ahb_write(CLEAR_OFFSET, 32'h00000001);
		repeat (STALL_CYC + 8) @(posedge hclk);
		check(32'(output_action), 32'(ACT_NORMAL));
		check(32'(fault_indicator_n), 32'h1);
	endtask

	initial begin
		repeat (10) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		check(32'(output_action), 32'(ACT_NORMAL));
		check(32'(fault_indicator_n), 32'h1);
		ahb_read(8'h0C, rd);
		check(rd, 32'h00000000);
		ahb_xfer(1'b1, CONFIG_OFFSET, 3'h0, 32'h00000555, rd);
		ahb_read(CONFIG_OFFSET, rd);
		check(rd, CONFIG_RESET);
		$display("test reset and registers done");
		// Latched phase overcurrent, clear refused while present
		sense <= 6'h01 << PIN_OCP;
		repeat (6) @(posedge hclk);
		ahb_write(CLEAR_OFFSET, 32'h00000001);
		repeat (4) @(posedge hclk);
		check(32'(output_action), 32'(ACT_HIZ));
		ahb_read(STATUS_OFFSET, rd);
		check(rd, (32'h1 << STS_OCP_BIT) | (32'(ACT_HIZ) << STS_ACT_LSB) | (32'h1 << STS_PIN_BIT));
		sense <= 6'h00;
		repeat (6) @(posedge hclk);
		check(32'(fault_indicator_n), 32'h0);
		ahb_write(CLEAR_OFFSET, 32'h00000001);
		repeat (4) @(posedge hclk);
		check(32'(output_action), 32'(ACT_NORMAL));
		check(32'(fault_indicator_n), 32'h1);
		$display("test latched overcurrent done");
		// Retrying phase overcurrent
		ahb_write(CONFIG_OFFSET, 32'(OCP_RETRY));
		sense <= 6'h01 << PIN_OCP;
		repeat (6) @(posedge hclk);
		check(32'(output_action), 32'(ACT_HIZ));
		sense <= 6'h00;
		repeat (4) @(posedge hclk);
		check(32'(output_action), 32'(ACT_HIZ));
		repeat (GEN_CYC + 4) @(posedge hclk);
		check(32'(output_action), 32'(ACT_NORMAL));
		check(32'(fault_indicator_n), 32'h1);
		$display("test retry overcurrent done");
		// Regulator overcurrent
		sense <= 6'h01 << PIN_REG;
		repeat (5) @(posedge hclk);
		check(32'(core_disable), 32'h1);
		check(32'(output_action), 32'(ACT_HIZ));
		check(32'(fault_indicator_n), 32'h1);
		sense <= 6'h00;
		repeat (5) @(posedge hclk);
		check(32'(core_disable), 32'h0);
		check(32'(output_action), 32'(ACT_NORMAL));
		$display("test regulator overcurrent done");
		for (int f = 0; f < 2; f++) begin
			for (int m = 0; m < 8; m++) begin
				fault_case(f, m);
			end
		end
		$display("test stall modes done");
		check(32'(assert_count), 32'd16);
		final_report();
	end
endmodule
